// [memctl_pkg.sv]
/*
 * Constants, register layouts and carrier types for the memory
 * controller reset and initialisation block.
 * Assumes a 32-bit APB with byte addresses on an 8-bit paddr.
 */
package memctl_pkg;

  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [7:0] OFS_CFG0   = 8'h00;
  localparam logic [7:0] OFS_CFG1   = 8'h04;
  localparam logic [7:0] OFS_CFG2   = 8'h08;
  localparam logic [7:0] OFS_EXP    = 8'h0C;
  localparam logic [7:0] OFS_SROM   = 8'h10;
  localparam logic [7:0] OFS_CAS00  = 8'h14;
  localparam logic [7:0] OFS_DCFG   = 8'h18;
  localparam logic [7:0] OFS_DREF   = 8'h1C;
  localparam logic [7:0] OFS_STAT   = 8'h20;

  // ****************************************************
  // Reset values and timing counts
  // ****************************************************
  localparam logic [12:0] CFG0_ONES = 13'h1FFF;
  localparam logic [2:0]  CAS_LAT_RST = 3'h4;
  localparam logic        RAS_LAT_RST = 1'h1;
  localparam logic [31:0] CAS00_RST = 32'h0000_0000;
  localparam logic [1:0]  INIT_CYC  = 2'h2;
  localparam logic [5:0]  ONE6      = 6'h01;

  // ****************************************************
  // Register layouts
  // ****************************************************
  typedef struct packed {
    logic [2:0] recovery_delay;
    logic [4:0] next_access_delay;
    logic [4:0] first_access_delay;
    logic       boot_bus_width_bit;
    logic [1:0] rom_type;
  } bank_cfg_type;

  typedef struct packed {
    bank_cfg_type odd;
    bank_cfg_type even;
  } static_cfg_type;

  typedef struct packed {
    logic       bank0_ras_latency;
    logic [2:0] bank0_cas_latency;
    logic [9:0] mid;
    logic [1:0] sync_rom_enable;
  } srom_cfg_type;

  typedef struct packed {
    logic [25:0] hi;
    logic [1:0]  dram_timing_select;
    logic [3:0]  dram_bank_enables;
  } dram_cfg_type;

  typedef struct packed {
    logic [13:0] hi;
    logic        bank0_keep_run;
    logic        bank0_early_pin;
    logic [3:0]  mid;
    logic [11:0] interval;
  } dref_cfg_type;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETUP, SEQ_STROBE, SEQ_HOLD} seq_type;

  // ****************************************************
  // Carriers
  // ****************************************************
  typedef struct packed {
    logic        valid;
    logic        dram;
    logic        write;
    logic        burst;
    logic [1:0]  bank;
    logic [31:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic [3:0]  chip_select_n;
    logic        write_strobe_n;
    logic        wdata_oe;
    logic [31:0] wdata;
  } mem_pins_type;

endpackage

// [memory_ctrl_reset_init.sv]
/*
 * Reset and boot initialisation of the external memory controller:
 * configuration registers on APB, static write sequencer, precharge
 * on nonburst access to a disabled dynamic bank, refresh counter.
 * Assumes soft and watchdog reset requests come from logic on pclk
 * and that the two strap pins are asynchronous board levels.
 */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
module memory_ctrl_reset_init
  import memctl_pkg::*;
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Reset requests and straps
  input  wire logic                   sleep_reset,
  input  wire logic                   soft_reset,
  input  wire logic                   wdog_reset,
  input  wire logic                   boot_width_select_pin,
  input  wire logic                   sync_rom_boot_enable_pin,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Memory side
  input  wire memctl_pkg::mem_req_type  mem_req,
  output memctl_pkg::mem_pins_type      mem_pins,
  output logic                        mem_done,
  output logic                        pall_cmd,
  output logic                        dram_go,
  output logic                        refresh_tick
);
  import memctl_pkg::*;

  typedef struct packed {
    logic           bw_s1;
    logic           bw_s2;
    logic           sm_s1;
    logic           sm_s2;
    logic           init;
    logic [1:0]     init_cnt;
    static_cfg_type cfg0;
    static_cfg_type cfg1;
    static_cfg_type cfg2;
    logic [31:0]    exp_cfg;
    srom_cfg_type   srom;
    logic [31:0]    cas00;
    dram_cfg_type   dcfg;
    dref_cfg_type   dref;
    logic [11:0]    ref_cnt;
    logic [3:0]     cause;
    seq_type        seq;
    logic [5:0]     cnt;
    logic [5:0]     len;
    mem_pins_type   pins;
    logic           done;
    logic           pall;
    logic           go;
    logic           tick;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
  } state_type;

  state_type st_q;
  state_type st_d;
  logic      wr_fire;

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a <= OFS_STAT) && (a[1:0] == 2'h0);
  endfunction

  function automatic bank_cfg_type bank_of(input state_type s, input logic [1:0] b);
    static_cfg_type c;
    c = b[1] ? s.cfg1 : s.cfg0;
    bank_of = b[0] ? c.odd : c.even;
  endfunction

  // Strobe low time: next delay for nonburst, first delay otherwise.
  function automatic logic [5:0] strobe_len(input bank_cfg_type c);
    logic [4:0] d;
    d = (c.rom_type == 2'h0) ? c.next_access_delay : c.first_access_delay;
    strobe_len = {1'b0, d} + ONE6;
  endfunction

  function automatic logic [31:0] read_word(input state_type s, input logic [7:0] a);
    unique case (a)
      OFS_CFG0:  read_word = s.cfg0;
      OFS_CFG1:  read_word = s.cfg1;
      OFS_CFG2:  read_word = s.cfg2;
      OFS_EXP:   read_word = s.exp_cfg;
      OFS_SROM:  read_word = {16'h0000, s.srom};
      OFS_CAS00: read_word = s.cas00;
      OFS_DCFG:  read_word = s.dcfg;
      OFS_DREF:  read_word = s.dref;
      OFS_STAT:  read_word = {4'h0, s.ref_cnt, 10'h000, s.seq != SEQ_IDLE, s.init, s.cause};
      default:   read_word = 32'h0000_0000;
    endcase
  endfunction

  assign wr_fire = psel && penable && pwrite && st_q.pready;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    st_d = st_q;
    st_d.bw_s1 = boot_width_select_pin;
    st_d.bw_s2 = st_q.bw_s1;
    st_d.sm_s1 = sync_rom_boot_enable_pin;
    st_d.sm_s2 = st_q.sm_s1;
    st_d.done = 1'b0;
    st_d.pall = 1'b0;
    st_d.go = 1'b0;
    st_d.tick = 1'b0;
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;

    // One wait state, so read data and pready both leave flops.
    if (psel && penable && !st_q.pready && !st_q.init)
    begin
      st_d.pready = 1'b1;
      st_d.prdata = read_word(st_q, paddr);
      st_d.pslverr = !addr_hit(paddr);
    end

    if (wr_fire)
    begin
      unique case (paddr)
        OFS_CFG0:  st_d.cfg0 = pwdata;
        OFS_CFG1:  st_d.cfg1 = pwdata;
        OFS_CFG2:  st_d.cfg2 = pwdata;
        OFS_EXP:   st_d.exp_cfg = pwdata;
        OFS_SROM:  st_d.srom = pwdata[15:0];
        OFS_CAS00: st_d.cas00 = pwdata;
        OFS_DCFG:  st_d.dcfg = pwdata;
        OFS_DREF:  st_d.dref = pwdata;
        default:   st_d.cause = st_q.cause;
      endcase
    end

    // Refresh runs only while some dynamic bank is enabled.
    if ((st_q.dcfg.dram_bank_enables != 4'h0) && (st_q.dref.interval != 12'h000))
    begin
      if (st_q.ref_cnt >= st_q.dref.interval)
      begin
        st_d.tick = 1'b1;
        st_d.ref_cnt = 12'h000;
      end
      else
      begin
        st_d.ref_cnt = st_q.ref_cnt + 12'h001;
      end
    end

    unique case (st_q.seq)
      SEQ_IDLE:
      begin
        if (mem_req.valid && !st_q.done && !st_q.init)
        begin
          if (mem_req.dram)
          begin
            st_d.done = 1'b1;
            if (!mem_req.burst && !st_q.dcfg.dram_bank_enables[mem_req.bank])
              st_d.pall = 1'b1;
            else if (st_q.dcfg.dram_bank_enables[mem_req.bank])
              st_d.go = 1'b1;
          end
          else if (mem_req.write)
          begin
            st_d.seq = SEQ_SETUP;
            st_d.pins.chip_select_n = ~(4'h1 << mem_req.bank);
            st_d.pins.wdata = mem_req.wdata;
            st_d.pins.wdata_oe = 1'b1;
            st_d.len = strobe_len(bank_of(st_q, mem_req.bank));
          end
          else
          begin
            st_d.done = 1'b1;
          end
        end
      end
      SEQ_SETUP:
      begin
        st_d.pins.write_strobe_n = 1'b0;
        st_d.cnt = st_q.len;
        st_d.seq = SEQ_STROBE;
      end
      SEQ_STROBE:
      begin
        if (st_q.cnt == ONE6)
        begin
          st_d.pins.write_strobe_n = 1'b1;
          st_d.seq = SEQ_HOLD;
        end
        else
        begin
          st_d.cnt = st_q.cnt - ONE6;
        end
      end
      SEQ_HOLD:
      begin
        st_d.pins.chip_select_n = 4'hF;
        st_d.pins.wdata_oe = 1'b0;
        st_d.done = 1'b1;
        st_d.seq = SEQ_IDLE;
      end
    endcase

    if (soft_reset || wdog_reset)
    begin
      st_d.seq = SEQ_IDLE;
      st_d.pins.chip_select_n = 4'hF;
      st_d.pins.write_strobe_n = 1'b1;
      st_d.pins.wdata_oe = 1'b0;
      st_d.cause = {wdog_reset, soft_reset, 2'h0};
    end

    if (sleep_reset)
    begin
      st_d.init = 1'b1;
      st_d.init_cnt = 2'h0;
      st_d.ref_cnt = 12'h000;
      st_d.tick = 1'b0;
      st_d.seq = SEQ_IDLE;
      st_d.pins.chip_select_n = 4'hF;
      st_d.pins.write_strobe_n = 1'b1;
      st_d.pins.wdata_oe = 1'b0;
      st_d.cause = 4'h2;
      // banks off at once
      // Without this the refresh counter would run on through the init phase.
      st_d.dcfg.dram_bank_enables = 4'h0;
    end
    else if (st_q.init)
    begin
      // Straps are loaded only once they have crossed both flops.
      if (st_q.init_cnt == INIT_CYC)
      begin
        st_d.init = 1'b0;
        st_d.cfg0.even = {CFG0_ONES, !st_q.bw_s2, 2'h0};
        st_d.srom.sync_rom_enable[0] = st_q.sm_s2;
        st_d.srom.bank0_cas_latency = CAS_LAT_RST;
        st_d.srom.bank0_ras_latency = RAS_LAT_RST;
        st_d.cas00 = CAS00_RST;
        st_d.dcfg.dram_bank_enables = 4'h0;
        st_d.dref.bank0_early_pin = st_q.sm_s2;
        st_d.dref.bank0_keep_run = st_q.sm_s2;
      end
      else
      begin
        st_d.init_cnt = st_q.init_cnt + 2'h1;
      end
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  // fields not named below reset to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.init <= 1'b1;
      st_q.cause <= 4'h1;
      st_q.pins.chip_select_n <= 4'hF;
      st_q.pins.write_strobe_n <= 1'b1;
      st_q.seq <= SEQ_IDLE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign mem_pins = st_q.pins;
  assign mem_done = st_q.done;
  assign pall_cmd = st_q.pall;
  assign dram_go = st_q.go;
  assign refresh_tick = st_q.tick;

  // ****************************************************
  // Checks
  // ****************************************************
  logic [5:0] low_run;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_run <= 6'h00;
    else if (!st_q.pins.write_strobe_n)
      low_run <= low_run + ONE6;
    else
      low_run <= 6'h00;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CFG0_BOOT: assert property ($fell(st_q.init) |->
    st_q.cfg0.even == {CFG0_ONES, !$past(st_q.bw_s2), 2'h0})
    else $error("cfg0 boot value wrong");
  AST_CFG0_SLOW: assert property ($fell(st_q.init) |->
    st_q.cfg0.even.first_access_delay == 5'h1F && st_q.cfg0.even.rom_type == 2'h0)
    else $error("boot bank not slowest nonburst");
  AST_SROM_EN_BOOT: assert property ($fell(st_q.init) |->
    st_q.srom.sync_rom_enable[0] == $past(st_q.sm_s2))
    else $error("bank0 sync ROM enable not strap");
  AST_CAS_LAT_BOOT: assert property ($fell(st_q.init) |->
    st_q.srom.bank0_cas_latency == 3'h4)
    else $error("CAS latency not 100");
  AST_RAS_LAT_BOOT: assert property ($fell(st_q.init) |->
    st_q.srom.bank0_ras_latency == 1'b1)
    else $error("RAS latency not one");
  AST_DRAM_OFF: assert property ($fell(st_q.init) |->
    st_q.dcfg.dram_bank_enables == 4'h0)
    else $error("dynamic banks enabled after boot");
  AST_REF_CLR: assert property ($rose(st_q.init) |-> st_q.ref_cnt == 12'h000)
    else $error("refresh counter not cleared");
  AST_SOFT_KEEP: assert property ((soft_reset || wdog_reset) && !wr_fire
    && !sleep_reset && !st_q.init |=> $stable(st_q.cfg0) && $stable(st_q.cfg1)
    && $stable(st_q.cfg2) && $stable(st_q.exp_cfg) && $stable(st_q.srom)
    && $stable(st_q.cas00) && $stable(st_q.dcfg) && $stable(st_q.dref)
    && (st_q.tick || (st_q.ref_cnt == $past(st_q.ref_cnt))
    || (st_q.ref_cnt == $past(st_q.ref_cnt) + 12'h001)))
    else $error("config changed by soft reset");
  AST_PALL: assert property (st_q.seq == SEQ_IDLE && mem_req.valid && mem_req.dram
    && !mem_req.burst && !st_q.done && !st_q.init && !sleep_reset
    && !st_q.dcfg.dram_bank_enables[mem_req.bank] |=> pall_cmd && !dram_go)
    else $error("no precharge on disabled bank");
  AST_STROBE_LEN: assert property ($rose(st_q.pins.write_strobe_n)
    && !$past(soft_reset || wdog_reset || sleep_reset) |-> low_run == $past(st_q.len)
    && st_q.pins.wdata_oe)
    else $error("write strobe length wrong");

  COV_SLEEP: cover property ($fell(st_q.init) ##1 st_q.cause == 4'h2);
  COV_PALL: cover property (pall_cmd);
  COV_WRITE: cover property ($rose(st_q.pins.write_strobe_n) ##1 mem_done);
  COV_SOFT: cover property (soft_reset && st_q.seq == SEQ_STROBE);

endmodule

// [mem_dev_model.sv]
/*
 * Far-side memory device model: watches the static write pins and
 * reports how long write data led the strobe rise, and what was written.
 * Assumes one access at a time on the pins.
 */
`timescale 1ns/10ps
module mem_dev_model
  import memctl_pkg::*;
(
  // Clock
  input  wire logic                      pclk,
  // Pins from the controller
  input  wire memctl_pkg::mem_pins_type  mem_pins,
  // Observations
  output logic      [7:0]                setup_cycles,
  output logic      [3:0]                cs_seen,
  output logic      [31:0]               wr_data
);
  logic [7:0] oe_cnt;
  logic       strobe_prev;

  initial
  begin
    oe_cnt = 8'h00;
    strobe_prev = 1'h1;
    setup_cycles = 8'h00;
    cs_seen = 4'hF;
    wr_data = 32'h0;
  end

  always @(posedge pclk)
  begin
    oe_cnt <= mem_pins.wdata_oe ? oe_cnt + 8'h01 : 8'h00;
    strobe_prev <= mem_pins.write_strobe_n;
    if (mem_pins.write_strobe_n && !strobe_prev)
    begin
      setup_cycles <= oe_cnt;
      cs_seen <= mem_pins.chip_select_n;
      wr_data <= mem_pins.wdata;
    end
  end
endmodule

// [test_memory_ctrl_reset_init.sv]
/*
 * Self-checking bench for the memory controller reset block.
 * Assumes the package offsets and the hand-over timing of APB and memory requests.
 */
`timescale 1ns/10ps
module test_memory_ctrl_reset_init;
  import memctl_pkg::*;
  typedef struct packed {logic [63:0] val; logic [63:0] msk;} note_type;
  localparam logic [63:0] DMSK = 64'h0000_0300_0000_0000;
  localparam logic [63:0] FULL = 64'h0000_3FFF_FFFF_FFFF;
  localparam logic [32:0] ALL  = 33'h1_FFFF_FFFF;
  logic pclk = 1'h0, presetn = 1'h0, sleep_reset = 1'h0, soft_reset = 1'h0;
  logic wdog_reset = 1'h0, width_pin = 1'h0, srom_pin = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
  logic mem_done, pall_cmd, dram_go, refresh_tick;
  logic [7:0] paddr = 8'h00, setup_cycles;
  logic [31:0] pwdata = 32'h0, prdata, wr_data, r1, r2;
  mem_req_type mem_req = '0;
  mem_pins_type mem_pins;
  logic [3:0] cs_seen;
  note_type apb_q[$], mem_q[$], nt;
  int mismatches = 0, checks = 0, cycles = 0, since = 0, gap = 0, g0, k, seed = 97511;

  always #2 pclk = ~pclk;

  memory_ctrl_reset_init dut (.pclk(pclk), .presetn(presetn), .sleep_reset(sleep_reset),
    .soft_reset(soft_reset), .wdog_reset(wdog_reset), .boot_width_select_pin(width_pin),
    .sync_rom_boot_enable_pin(srom_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_pins(mem_pins), .mem_done(mem_done), .pall_cmd(pall_cmd),
    .dram_go(dram_go), .refresh_tick(refresh_tick));

  mem_dev_model far_end (.pclk(pclk), .mem_pins(mem_pins), .setup_cycles(setup_cycles),
    .cs_seen(cs_seen), .wr_data(wr_data));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************
  // Result monitor
  // ****************************************************
  always @(posedge pclk)
  begin
    cycles++;
    since++;
    if (refresh_tick === 1'h1)
    begin
      gap = since;
      since = 0;
    end
    if (psel && penable && pready === 1'h1 && apb_q.size() > 0)
    begin
      nt = apb_q.pop_front();
      check("apb", {31'h0, pslverr, prdata} & nt.msk, nt.val & nt.msk);
    end
    if (mem_done === 1'h1 && mem_q.size() > 0)
    begin
      nt = mem_q.pop_front();
      check("mem", {18'h0, cs_seen, pall_cmd, dram_go, setup_cycles, wr_data} & nt.msk,
            nt.val & nt.msk);
    end
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // ****************************************************
  // Drivers
  // ****************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp, input logic [32:0] msk);
    apb_q.push_back('{{31'h0, exp}, {31'h0, msk}});
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic mem(input logic dram, input logic wr, input logic burst, input logic [1:0] bank,
                     input logic [1:0] resp, input logic [7:0] setup, input logic [63:0] msk);
    logic [31:0] d;
    d = $random(seed);
    mem_q.push_back('{{18'h0, ~(4'h1 << bank), resp, setup, d}, msk});
    @(posedge pclk);
    mem_req <= '{1'h1, dram, wr, burst, bank, d};
    @(posedge pclk);
    while (mem_done !== 1'h1) @(posedge pclk);
    mem_req.valid <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic pulse(input int which);
    @(posedge pclk);
    sleep_reset <= (which == 0);
    soft_reset <= (which == 1);
    wdog_reset <= (which == 2);
    @(posedge pclk);
    {sleep_reset, soft_reset, wdog_reset} <= 3'h0;
  endtask

  task automatic wait_tick();
    @(posedge pclk);
    while (refresh_tick !== 1'h1) @(posedge pclk);
    @(posedge pclk);
  endtask

  function automatic logic [7:0] setup_of(input logic [15:0] f);
    return (f[1:0] == 2'h0) ? {3'h0, f[12:8]} + 8'h02 : {3'h0, f[7:3]} + 8'h02;
  endfunction

  task automatic boot_checks();
    apb(1'h0, OFS_CFG0, 32'h0, {17'h0, CFG0_ONES, ~width_pin, 2'h0}, 33'h1_0000_FFFF);
    apb(1'h0, OFS_SROM, 32'h0, {17'h0, RAS_LAT_RST, CAS_LAT_RST, 11'h0, srom_pin},
        33'h1_0000_F001);
    apb(1'h0, OFS_CAS00, 32'h0, {1'h0, CAS00_RST}, ALL);
    apb(1'h0, OFS_DCFG, 32'h0, 33'h0, 33'h1_0000_000F);
    apb(1'h0, OFS_DREF, 32'h0, {15'h0, srom_pin, srom_pin, 16'h0}, 33'h1_0003_0000);
    apb(1'h0, OFS_STAT, 32'h0, 33'h0, 33'h1_0FFF_0000);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  initial
  begin
    r1 = $random(seed);
    r2 = $random(seed);
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    boot_checks();
    $display("test hardware reset done");
    apb(1'h1, OFS_CFG0, 32'h090A_0238, 33'h0, 33'h0);
    apb(1'h1, OFS_CFG1, r1, 33'h0, 33'h0);
    apb(1'h1, OFS_EXP, r2, 33'h0, 33'h0);
    for (k = 1; k < 3; k++)
    begin
      pulse(k);
      apb(1'h0, OFS_CFG0, 32'h0, 33'h0_090A_0238, ALL);
      apb(1'h0, OFS_CFG1, 32'h0, {1'h0, r1}, ALL);
      apb(1'h0, OFS_EXP, 32'h0, {1'h0, r2}, ALL);
      apb(1'h0, OFS_STAT, 32'h0, {29'h0, 4'h1 << (k + 1)}, 33'h1_0000_000F);
    end
    $display("test soft and watchdog keep done");
    mem(1'h0, 1'h1, 1'h0, 2'h0, 2'h0, setup_of(16'h0238), FULL);
    mem(1'h0, 1'h1, 1'h0, 2'h1, 2'h0, setup_of(16'h090A), FULL);
    mem(1'h0, 1'h0, 1'h0, 2'h1, 2'h0, 8'h00, DMSK);
    $display("test static write done");
    apb(1'h1, OFS_DREF, 32'h0000_0010, 33'h0, 33'h0);
    apb(1'h1, OFS_DCFG, 32'h0000_0031, 33'h0, 33'h0);
    mem(1'h1, 1'h0, 1'h0, 2'h0, 2'h1, 8'h00, DMSK);
    mem(1'h1, 1'h1, 1'h0, 2'h2, 2'h2, 8'h00, DMSK);
    mem(1'h1, 1'h0, 1'h1, 2'h2, 2'h0, 8'h00, DMSK);
    wait_tick();
    wait_tick();
    g0 = gap;
    pulse(2);
    wait_tick();
    check("refresh gap", gap, g0);
    check("refresh period", g0, 64'h11);
    $display("test dynamic access done");
    pulse(1);
    apb(1'h1, OFS_DCFG, 32'h0000_0030, 33'h0, 33'h0);
    mem(1'h1, 1'h0, 1'h0, 2'h0, 2'h2, 8'h00, DMSK);
    apb(1'h1, OFS_DCFG, 32'h0000_0031, 33'h0, 33'h0);
    apb(1'h0, OFS_DCFG, 32'h0, 33'h0_0000_0031, 33'h1_0000_003F);
    apb(1'h0, 8'h24, 32'h0, 33'h1_0000_0000, ALL);
    apb(1'h1, 8'h02, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    $display("test precharge sequence done");
    // width strap low with boot strap
    srom_pin <= 1'h1;
    repeat (4) @(posedge pclk);
    pulse(0);
    boot_checks();
    apb(1'h0, OFS_CFG0, 32'h0, 33'h0_090A_0000, 33'h1_FFFF_0000);
    apb(1'h0, OFS_CFG1, 32'h0, {1'h0, r1}, ALL);
    apb(1'h0, OFS_EXP, 32'h0, {1'h0, r2}, ALL);
    mem(1'h0, 1'h1, 1'h0, 2'h0, 2'h0, setup_of(16'hFFFC), FULL);
    mem(1'h1, 1'h0, 1'h0, 2'h0, 2'h2, 8'h00, DMSK);
    $display("test sleep reset done");
    srom_pin <= 1'h0;
    width_pin <= 1'h1;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    boot_checks();
    $display("test second hardware reset done");
    repeat (4) @(posedge pclk);
    print_verdict();
  end
endmodule
